// ### rtl/stg_defs.svh
`ifndef STG_DEFS_SVH
`define STG_DEFS_SVH

// Register indices; byte address is four times the index
`define STG_IDX_CTRL        8'h80
`define STG_IDX_RST_BEGIN   8'h83
`define STG_IDX_RST_FINISH  8'h84
`define STG_IDX_IRQ_BEGIN   8'h85
`define STG_IDX_IRQ_FINISH  8'h86
`define STG_IDX_EVT_STATUS  8'h90
`define STG_IDX_EVT_MASK    8'h91
`define STG_IDX_POSITION    8'h92

// Control register fields
`define STG_CTRL_EN_BIT     0
`define STG_CTRL_CNT_LSB    1
`define STG_CTRL_CNT_MSB    16
`define STG_CTRL_ACFG_BIT   23

// Reset values
`define STG_RST_CNT         16'h270F
`define STG_RST_RST_BEGIN   16'h00D0
`define STG_RST_RST_FINISH  16'h00D8
`define STG_RST_IRQ_BEGIN   16'h0020
`define STG_RST_IRQ_FINISH  16'h0028

// Event status bits
`define STG_EVT_SUBFRAME    0
`define STG_EVT_RST_PULSE   1
`define STG_EVT_IRQ_PULSE   2
`define STG_EVT_WIDTH       3

// Bus responses
`define STG_RESP_OKAY       2'h0
`define STG_RESP_SLVERR     2'h2

`endif

// ### rtl/stg_pkg.sv
package stg_pkg;

    typedef struct packed {
        logic        acfg_disable;
        logic [15:0] clock_count;
        logic        enable;
    } stg_ctrl_type;

    typedef struct packed {
        logic [15:0] begin_pos;
        logic [15:0] finish_pos;
    } stg_window_type;

    typedef struct packed {
        logic        rst_pulse;
        logic        irq_pulse;
        logic        subframe_start;
    } stg_events_type;

endpackage

// ### rtl/stg_pulse_window.sv
`timescale 1ns/1ps
`default_nettype none

module stg_pulse_window (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Position and window
    input  wire logic                    run,
    input  wire logic [15:0]             pos,
    input  wire stg_pkg::stg_window_type win,
    // Pulse outputs
    output var  logic                    pulse_q,
    output var  logic                    rise_q
);

    logic pulse_d;
    logic rise_d;

    // High for positions begin..finish-1, so width is finish minus begin
    always_comb begin
        pulse_d = run && (pos >= win.begin_pos) &&
                  (pos < win.finish_pos);
        rise_d  = pulse_d && !pulse_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            rise_q  <= rise_d;
        end
    end

endmodule

`default_nettype wire

// ### rtl/stg_timing_generator.sv
// What this block does
// - Timing unit runs only while enable bit is 1; enable resets to 0.
// - Sub-frame length comes from 16-bit count in control bits 16:1, reset 270Fh.
// - Auto-config disable bit 23 stops automatic mask timing setup.
// - Datapath reset pulse starts at the reset-begin position, reset D0h.
// - Datapath reset pulse ends at the reset-finish position, reset D8h.
// - Datapath reset pulse lasts finish minus begin generator clocks.
// - Sequencer interrupt pulse starts at its begin position, reset 20h.
// - Sequencer interrupt pulse ends at its finish position, reset 28h.
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "stg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module stg_timing_generator (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Timing outputs
    output var  logic        datapath_reset_pulse,
    output var  logic        seq_irq_pulse,
    output var  logic        subframe_start,
    output var  logic        auto_config_enable,
    // Interrupt
    output var  logic        irq
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [23:0] merge24(input logic [23:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        logic [23:0] r;
        r = old;
        for (int b = 0; b < 3; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [9:0] word_index(input logic [11:0] a);
        return a[11:2];
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    stg_pkg::stg_ctrl_type   ctrl_q,    ctrl_d;
    stg_pkg::stg_window_type rstw_q,    rstw_d;
    stg_pkg::stg_window_type irqw_q,    irqw_d;
    logic [`STG_EVT_WIDTH-1:0] status_q, status_d;
    logic [`STG_EVT_WIDTH-1:0] mask_q,   mask_d;

    logic [11:0] awaddr_q,  awaddr_d;
    logic        aw_full_q, aw_full_d;
    logic [31:0] wdata_q,   wdata_d;
    logic [3:0]  wstrb_q,   wstrb_d;
    logic        w_full_q,  w_full_d;
    logic        awready_d, wready_d;
    logic [1:0]  bresp_d;
    logic        bvalid_d;
    logic        arready_d;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_d;
    logic        rvalid_d;

    logic [15:0] pos_q, pos_d;
    logic        run_q, run_d;
    logic        start_d;
    logic        acfg_d;
    logic        irq_d;

    logic        rst_pulse;
    logic        rst_rise;
    logic        irq_pulse;
    logic        irq_rise;
    stg_pkg::stg_events_type evt;

    // ==========================================================
    // Pulse windows
    // ==========================================================
    stg_pulse_window u_rst_window (
        .clk     (clk),
        .rst     (rst),
        .run     (run_q),
        .pos     (pos_q),
        .win     (rstw_q),
        .pulse_q (rst_pulse),
        .rise_q  (rst_rise)
    );

    stg_pulse_window u_irq_window (
        .clk     (clk),
        .rst     (rst),
        .run     (run_q),
        .pos     (pos_q),
        .win     (irqw_q),
        .pulse_q (irq_pulse),
        .rise_q  (irq_rise)
    );

    // ==========================================================
    // Position counter
    // ==========================================================
    always_comb begin
        run_d   = ctrl_q.enable;
        pos_d   = 16'h0000;
        start_d = 1'b0;
        if (run_q && ctrl_q.enable) begin
            start_d = (pos_q == 16'h0000);
            if (pos_q + 16'h0001 >= ctrl_q.clock_count) begin
                pos_d = 16'h0000;
            end else begin
                pos_d = pos_q + 16'h0001;
            end
        end
        acfg_d = !ctrl_q.acfg_disable;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_q              <= 16'h0000;
            run_q              <= 1'b0;
            subframe_start     <= 1'b0;
            auto_config_enable <= 1'b1;
        end else begin
            pos_q              <= pos_d;
            run_q              <= run_d;
            subframe_start     <= start_d;
            auto_config_enable <= acfg_d;
        end
    end

    always_comb begin
        evt.subframe_start = start_d;
        evt.rst_pulse      = rst_rise;
        evt.irq_pulse      = irq_rise;
    end

    // ==========================================================
    // AXI4-Lite slave and registers
    // ==========================================================
    always_comb begin
        logic [9:0]  widx;
        logic [9:0]  ridx;
        logic [23:0] cw;
        logic [`STG_EVT_WIDTH-1:0] sets;
        logic        do_write;
        widx = word_index(awaddr_q);
        ridx = word_index(s_axi_araddr);
        cw   = 24'h000000;
        sets = {evt.irq_pulse, evt.rst_pulse, evt.subframe_start};
        do_write = aw_full_q && w_full_q && !s_axi_bvalid;

        ctrl_d    = ctrl_q;
        rstw_d    = rstw_q;
        irqw_d    = irqw_q;
        mask_d    = mask_q;
        status_d  = status_q;
        awaddr_d  = awaddr_q;
        aw_full_d = aw_full_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        w_full_d  = w_full_q;
        bresp_d   = s_axi_bresp;
        bvalid_d  = s_axi_bvalid;
        rdata_d   = s_axi_rdata;
        rresp_d   = s_axi_rresp;
        rvalid_d  = s_axi_rvalid;

        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_d  = s_axi_awaddr;
            aw_full_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
            w_full_d = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `STG_RESP_OKAY;
            if (widx == 10'(`STG_IDX_CTRL)) begin
                cw = merge24({ctrl_q.acfg_disable, 6'h00,
                              ctrl_q.clock_count, ctrl_q.enable},
                             wdata_q, wstrb_q);
                ctrl_d.enable       = cw[`STG_CTRL_EN_BIT];
                ctrl_d.clock_count  =
                    cw[`STG_CTRL_CNT_MSB:`STG_CTRL_CNT_LSB];
                ctrl_d.acfg_disable = cw[`STG_CTRL_ACFG_BIT];
            end else if (widx == 10'(`STG_IDX_RST_BEGIN)) begin
                cw = merge24({8'h00, rstw_q.begin_pos}, wdata_q, wstrb_q);
                rstw_d.begin_pos = cw[15:0];
            end else if (widx == 10'(`STG_IDX_RST_FINISH)) begin
                cw = merge24({8'h00, rstw_q.finish_pos}, wdata_q, wstrb_q);
                rstw_d.finish_pos = cw[15:0];
            end else if (widx == 10'(`STG_IDX_IRQ_BEGIN)) begin
                cw = merge24({8'h00, irqw_q.begin_pos}, wdata_q, wstrb_q);
                irqw_d.begin_pos = cw[15:0];
            end else if (widx == 10'(`STG_IDX_IRQ_FINISH)) begin
                cw = merge24({8'h00, irqw_q.finish_pos}, wdata_q, wstrb_q);
                irqw_d.finish_pos = cw[15:0];
            end else if (widx == 10'(`STG_IDX_EVT_STATUS)) begin
                if (wstrb_q[0]) begin
                    status_d = status_q &
                               ~wdata_q[`STG_EVT_WIDTH-1:0];
                end
            end else if (widx == 10'(`STG_IDX_EVT_MASK)) begin
                if (wstrb_q[0]) begin
                    mask_d = wdata_q[`STG_EVT_WIDTH-1:0];
                end
            end else if (widx == 10'(`STG_IDX_POSITION)) begin
                bresp_d = `STG_RESP_OKAY;
            end else begin
                bresp_d = `STG_RESP_SLVERR;
            end
        end
        // Set wins over a same-cycle clear
        status_d = status_d | sets;

        awready_d = !aw_full_d && !bvalid_d;
        wready_d  = !w_full_d && !bvalid_d;

        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = `STG_RESP_OKAY;
            rdata_d  = 32'h00000000;
            if (ridx == 10'(`STG_IDX_CTRL)) begin
                rdata_d[`STG_CTRL_EN_BIT] = ctrl_q.enable;
                rdata_d[`STG_CTRL_CNT_MSB:`STG_CTRL_CNT_LSB] =
                    ctrl_q.clock_count;
                rdata_d[`STG_CTRL_ACFG_BIT] = ctrl_q.acfg_disable;
            end else if (ridx == 10'(`STG_IDX_RST_BEGIN)) begin
                rdata_d[15:0] = rstw_q.begin_pos;
            end else if (ridx == 10'(`STG_IDX_RST_FINISH)) begin
                rdata_d[15:0] = rstw_q.finish_pos;
            end else if (ridx == 10'(`STG_IDX_IRQ_BEGIN)) begin
                rdata_d[15:0] = irqw_q.begin_pos;
            end else if (ridx == 10'(`STG_IDX_IRQ_FINISH)) begin
                rdata_d[15:0] = irqw_q.finish_pos;
            end else if (ridx == 10'(`STG_IDX_EVT_STATUS)) begin
                rdata_d[`STG_EVT_WIDTH-1:0] = status_q;
            end else if (ridx == 10'(`STG_IDX_EVT_MASK)) begin
                rdata_d[`STG_EVT_WIDTH-1:0] = mask_q;
            end else if (ridx == 10'(`STG_IDX_POSITION)) begin
                rdata_d[15:0] = pos_q;
                rdata_d[16]   = run_q;
            end else begin
                rresp_d = `STG_RESP_SLVERR;
            end
        end
        arready_d = !rvalid_d;

        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q.enable       <= 1'b0;
            ctrl_q.clock_count  <= `STG_RST_CNT;
            ctrl_q.acfg_disable <= 1'b0;
            rstw_q.begin_pos    <= `STG_RST_RST_BEGIN;
            rstw_q.finish_pos   <= `STG_RST_RST_FINISH;
            irqw_q.begin_pos    <= `STG_RST_IRQ_BEGIN;
            irqw_q.finish_pos   <= `STG_RST_IRQ_FINISH;
            status_q            <= '0;
            mask_q              <= '0;
            awaddr_q            <= 12'h000;
            aw_full_q           <= 1'b0;
            wdata_q             <= 32'h00000000;
            wstrb_q             <= 4'h0;
            w_full_q            <= 1'b0;
            s_axi_awready       <= 1'b0;
            s_axi_wready        <= 1'b0;
            s_axi_bresp         <= 2'h0;
            s_axi_bvalid        <= 1'b0;
            s_axi_arready       <= 1'b0;
            s_axi_rdata         <= 32'h00000000;
            s_axi_rresp         <= 2'h0;
            s_axi_rvalid        <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            ctrl_q              <= ctrl_d;
            rstw_q              <= rstw_d;
            irqw_q              <= irqw_d;
            status_q            <= status_d;
            mask_q              <= mask_d;
            awaddr_q            <= awaddr_d;
            aw_full_q           <= aw_full_d;
            wdata_q             <= wdata_d;
            wstrb_q             <= wstrb_d;
            w_full_q            <= w_full_d;
            s_axi_awready       <= awready_d;
            s_axi_wready        <= wready_d;
            s_axi_bresp         <= bresp_d;
            s_axi_bvalid        <= bvalid_d;
            s_axi_arready       <= arready_d;
            s_axi_rdata         <= rdata_d;
            s_axi_rresp         <= rresp_d;
            s_axi_rvalid        <= rvalid_d;
            irq                 <= irq_d;
        end
    end

    always_comb begin
        datapath_reset_pulse = rst_pulse;
        seq_irq_pulse        = irq_pulse;
    end

endmodule

`default_nettype wire

// ### tb/stg_timing_generator_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "stg_defs.svh"

module stg_timing_generator_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff rst;

    // ==========================================================
    // Bus transfer steps
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    write_resp_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_resp_a: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read data late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    write_busy_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    resp_code_a: assert property (s_axi_bvalid |->
        s_axi_bresp == `STG_RESP_OKAY || s_axi_bresp == `STG_RESP_SLVERR)
        else $error("bad write response code");
    err_data_a: assert property (s_axi_rvalid
        && s_axi_rresp == `STG_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    bresp_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("write response repeated");
    rdata_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid)
        else $error("read data repeated");
endmodule

bind stg_timing_generator stg_timing_generator_monitor u_mon (
    .clk(clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

`default_nettype wire

// ### tb/stg_timing_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "stg_defs.svh"

module stg_timing_generator_tb;
    logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        dp_pulse, irq_pulse, sf_start, acfg_en, irq, sf, hi;
    int          miscompares, n_tests, f1, w1, f2, w2;

    stg_timing_generator dut (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .datapath_reset_pulse(dp_pulse), .seq_irq_pulse(irq_pulse),
        .subframe_start(sf_start), .auto_config_enable(acfg_en),
        .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Checking and closing
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chkb(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task tmo;
        miscompares++;
        $display("ERROR at %0t: wait limit reached", $time);
        wrap_up();
    endtask

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // ==========================================================
    // Bus access
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw;
        n = 0;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (awready && !ta) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !tw) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
            if (++n > 50) tmo();
        end
        repeat (3) @(posedge clk);
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (++n > 50) tmo();
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (++n > 50) tmo();
        end while (!arready);
        arvalid <= 1'b0;
        repeat (2) @(posedge clk);
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (++n > 50) tmo();
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // One sub-frame of 20 clocks after a start pulse
    task measure;
        int n;
        n = 0;
        f1 = -1;
        f2 = -1;
        w1 = 0;
        w2 = 0;
        do begin
            @(posedge clk);
            #1;
            if (++n > 200) tmo();
        end while (sf_start !== 1'b1);
        for (int k = 1; k <= 20; k++) begin
            @(posedge clk);
            #1;
            if (dp_pulse === 1'b1) begin
                if (f1 < 0) f1 = k;
                w1++;
            end
            if (irq_pulse === 1'b1) begin
                if (f2 < 0) f2 = k;
                w2++;
            end
        end
        sf = sf_start;
    endtask

    // ==========================================================
    // Main sequence
    logic [11:0] ra [7] = '{12'h200, 12'h20C, 12'h210, 12'h214,
                            12'h218, 12'h240, 12'h244};
    logic [31:0] rv [7] = '{32'h00004E1E, 32'hD0, 32'hD8, 32'h20,
                            32'h28, 32'h0, 32'h0};

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3F & 6'h20;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        miscompares = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rdc(ra[i], rv[i], `STG_RESP_OKAY);
        end
        chkb(acfg_en, 1'b1);
        wr(ba(`STG_IDX_CTRL), 32'h0081FFFE, `STG_RESP_OKAY);
        rdc(ba(`STG_IDX_CTRL), 32'h0081FFFE, `STG_RESP_OKAY);
        chkb(acfg_en, 1'b0);
        wr(12'h3FC, 32'h1, `STG_RESP_SLVERR);
        rdc(12'h3FC, 32'h0, `STG_RESP_SLVERR);
        wr(ba(`STG_IDX_RST_BEGIN), 32'h5, `STG_RESP_OKAY);
        wr(ba(`STG_IDX_RST_FINISH), 32'h9, `STG_RESP_OKAY);
        wr(ba(`STG_IDX_IRQ_BEGIN), 32'h3, `STG_RESP_OKAY);
        wr(ba(`STG_IDX_IRQ_FINISH), 32'h4, `STG_RESP_OKAY);
        wr(ba(`STG_IDX_CTRL), 32'h29, `STG_RESP_OKAY);
        measure();
        chk(f1, 32'd5);
        chk(w1, 32'd4);
        chk(f2, 32'd3);
        chk(w2, 32'd1);
        chkb(sf, 1'b1);
        chkb(acfg_en, 1'b1);
        chkb(irq, 1'b0);
        wr(ba(`STG_IDX_EVT_MASK), 32'h2, `STG_RESP_OKAY);
        chkb(irq, 1'b1);
        wr(ba(`STG_IDX_CTRL), 32'h28, `STG_RESP_OKAY);
        hi = 1'b0;
        repeat (25) begin
            @(posedge clk);
            #1;
            hi = hi | dp_pulse | irq_pulse | sf_start;
        end
        chkb(hi, 1'b0);
        rdc(ba(`STG_IDX_POSITION), 32'h0, `STG_RESP_OKAY);
        rdc(ba(`STG_IDX_EVT_STATUS), 32'h7, `STG_RESP_OKAY);
        wr(ba(`STG_IDX_EVT_STATUS), 32'h7, `STG_RESP_OKAY);
        rdc(ba(`STG_IDX_EVT_STATUS), 32'h0, `STG_RESP_OKAY);
        chkb(irq, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
